/* File: logic/vrc_pkg.sv */
// Package for the voltage reference control register block.
package vrc_pkg;

    localparam logic [7:0] VRC_REF_CTRL_ADDR = 8'h00_D1;
    localparam logic [3:0] VRC_REF_CTRL_PAGE = 4'h0;
    localparam logic [7:0] VRC_REF_CTRL_RST = 8'h00_00;
    localparam logic [7:0] VRC_WRITE_MASK = 8'h00_1F;
    localparam logic [7:0] VRC_WRITE_MASK_NOSEL = 8'h00_07;
    localparam int VRC_BIT_PRI_SEL = 4;
    localparam int VRC_BIT_SEC_SEL = 3;
    localparam int VRC_BIT_TEMP = 2;
    localparam int VRC_BIT_BIAS = 1;
    localparam int VRC_BIT_BUF = 0;

    // Build variants of the reference subsystem.
    typedef enum logic [1:0] {
        VRC_SEPARATE_PINS,
        VRC_SHARED_PIN,
        VRC_NO_SELECTS
    } vrc_variant_t;

    // Primary converter reference sources.
    typedef enum logic [1:0] {
        VRC_PRI_SEP_PIN,
        VRC_PRI_SHARED_PIN,
        VRC_PRI_CONV_OUT,
        VRC_PRI_NONE
    } vrc_pri_src_t;

    // Secondary converter reference sources.
    typedef enum logic [1:0] {
        VRC_SEC_SEP_PIN,
        VRC_SEC_SHARED_PIN,
        VRC_SEC_SUPPLY,
        VRC_SEC_NONE
    } vrc_sec_src_t;

    // Special-function bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrc_sfr_req_t;

    // Analog control outputs.
    typedef struct packed {
        vrc_pri_src_t pri_src;
        vrc_sec_src_t sec_src;
        logic temp_en;
        logic bias_en;
        logic buf_en;
    } vrc_analog_t;

endpackage

/* File: logic/vrc_reference_control.sv */
// Reference control register and its analog control decode.
`timescale 1ns/1ps
`default_nettype none
module vrc_reference_control #(
    parameter vrc_pkg::vrc_variant_t VARIANT = vrc_pkg::VRC_SEPARATE_PINS
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire vrc_pkg::vrc_sfr_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_hit,
    output vrc_pkg::vrc_analog_t o_analog,
    output logic o_sensor_mux_en,
    output logic o_ref_buf_oe
);
    import vrc_pkg::*;

    // The block is one byte of control state on the special-function bus.
    // Software writes it and reads it back; every writable bit is a static level
    // that steers a piece of the analog reference subsystem. Nothing here is
    // sequenced: a bit written on one edge is seen by the analog side right
    // after it. The cost is that software alone owns the enable order. For
    // example, the bias generator must be on before a converter is used, and
    // the block does not enforce that. The build variant decides how the two
    // select bits are decoded, or whether they are kept at all.

    localparam logic [7:0] WMASK = (VARIANT == VRC_NO_SELECTS) ? VRC_WRITE_MASK_NOSEL
                                                                : VRC_WRITE_MASK;

    // Reset values of the source selects are the decode of an all-zero register
    // in this variant. Then the outputs during reset already match what the
    // first clock edge would give, and no false change follows the release.
    localparam vrc_pri_src_t PRI_RST = vrc_pri_src_t'((VARIANT == VRC_SHARED_PIN)
        ? VRC_PRI_SHARED_PIN : ((VARIANT == VRC_NO_SELECTS) ? VRC_PRI_NONE
        : VRC_PRI_SEP_PIN));
    localparam vrc_sec_src_t SEC_RST = vrc_sec_src_t'((VARIANT == VRC_SHARED_PIN)
        ? VRC_SEC_SHARED_PIN : ((VARIANT == VRC_NO_SELECTS) ? VRC_SEC_NONE
        : VRC_SEC_SEP_PIN));

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;
    vrc_analog_t analog_r;
    vrc_analog_t analog_nxt;
    logic sel;

    // Address decode: page and address must both match.
    assign sel = (i_req.addr == VRC_REF_CTRL_ADDR) && (i_req.page == VRC_REF_CTRL_PAGE);

    // Next register contents; unused bits never load, so they read zero.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (i_req.wr && sel) begin
            ctrl_nxt = i_req.wdata & WMASK;
        end
        hit_nxt = i_req.rd && sel;
        rdata_nxt = (i_req.rd && sel) ? (ctrl_r & WMASK) : 8'h00_00;
    end

    // Decode of the control bits into analog controls, computed from the next value
    // so the outputs change on the same edge as the register itself.
    always_comb begin
        analog_nxt.temp_en = ctrl_nxt[VRC_BIT_TEMP];
        analog_nxt.bias_en = ctrl_nxt[VRC_BIT_BIAS];
        analog_nxt.buf_en = ctrl_nxt[VRC_BIT_BUF];
        case (VARIANT)
            VRC_SEPARATE_PINS: begin
                analog_nxt.pri_src = ctrl_nxt[VRC_BIT_PRI_SEL] ? VRC_PRI_CONV_OUT
                                                               : VRC_PRI_SEP_PIN;
                analog_nxt.sec_src = ctrl_nxt[VRC_BIT_SEC_SEL] ? VRC_SEC_SUPPLY
                                                               : VRC_SEC_SEP_PIN;
            end
            VRC_SHARED_PIN: begin
                analog_nxt.pri_src = ctrl_nxt[VRC_BIT_PRI_SEL] ? VRC_PRI_CONV_OUT
                                                               : VRC_PRI_SHARED_PIN;
                analog_nxt.sec_src = ctrl_nxt[VRC_BIT_SEC_SEL] ? VRC_SEC_SUPPLY
                                                               : VRC_SEC_SHARED_PIN;
            end
            default: begin
                // No mux in this variant; the reserved bits steer nothing.
                analog_nxt.pri_src = VRC_PRI_NONE;
                analog_nxt.sec_src = VRC_SEC_NONE;
            end
        endcase
    end

    // All state clears to zero on reset, except the source selects, which load PRI_RST and SEC_RST.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= VRC_REF_CTRL_RST;
            rdata_r <= 8'h00_00;
            hit_r <= 1'b0;
            analog_r <= '{pri_src: PRI_RST, sec_src: SEC_RST,
                          temp_en: 1'b0, bias_en: 1'b0, buf_en: 1'b0};
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
            analog_r <= analog_nxt;
        end
    end

    // Every output is a register, so the analog side never sees decode glitches.
    assign o_rdata = rdata_r;
    assign o_hit = hit_r;
    assign o_analog = analog_r;
    // Sensor joins the top mux input only while enabled, otherwise it floats.
    assign o_sensor_mux_en = analog_r.temp_en;
    // Buffer drives the pin only while enabled; the enable low means high impedance.
    assign o_ref_buf_oe = analog_r.buf_en;

    // Shadow of the register for the checks only. It decodes the bus by itself,
    // so a broken select in the main path cannot also hide in the check; both paths use the same WMASK.
    logic [7:0] shadow_r;
    logic [7:0] shadow_nxt;

    // Next shadow value from the raw bus request.
    always_comb begin
        shadow_nxt = shadow_r;
        if (i_req.wr && (i_req.addr == VRC_REF_CTRL_ADDR)
            && (i_req.page == VRC_REF_CTRL_PAGE)) begin
            shadow_nxt = i_req.wdata & WMASK;
        end
    end

    // Shadow register, cleared with the rest of the state.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shadow_r <= VRC_REF_CTRL_RST;
        end else begin
            shadow_r <= shadow_nxt;
        end
    end

    // Checks on the register contents.
    chk_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctrl_r[7:5] == 3'b000) else $error("reserved bits not zero");

    chk_shadow_match: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctrl_r == shadow_r) else $error("register differs from shadow");

    // The write lands on the edge that takes it, masked by the variant.
    chk_write_update: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_req.wr && sel) |=> ctrl_r == ($past(i_req.wdata) & WMASK))
        else $error("write did not land");

    // Requests to any other page or address leave the register alone.
    chk_no_stray_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !(i_req.wr && sel) |=> $stable(ctrl_r)) else $error("register changed without write");

    // Read data stands for one cycle after a hit read.
    chk_read_data: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_req.rd && sel) |=> o_hit && o_rdata == $past(ctrl_r & WMASK))
        else $error("read data wrong");

    // A miss or an idle cycle leaves the read bus at zero, without a hit.
    chk_miss_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !(i_req.rd && sel) |=> !o_hit && o_rdata == 8'h00_00)
        else $error("read answered without a hit");

    // Enable bits drive their analog controls directly.
    chk_temp_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_analog.temp_en == ctrl_r[VRC_BIT_TEMP] && o_sensor_mux_en == ctrl_r[VRC_BIT_TEMP])
        else $error("sensor enable mismatch");
    chk_bias_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_analog.bias_en == ctrl_r[VRC_BIT_BIAS]) else $error("bias enable mismatch");
    chk_buf_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_ref_buf_oe == ctrl_r[VRC_BIT_BUF] && o_analog.buf_en == ctrl_r[VRC_BIT_BUF])
        else $error("buffer enable mismatch");

    // A set select picks the internal source in both variants with a mux.
    chk_pri_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT != VRC_NO_SELECTS && ctrl_r[VRC_BIT_PRI_SEL]) |-> o_analog.pri_src == VRC_PRI_CONV_OUT)
        else $error("primary select wrong");
    chk_sec_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT != VRC_NO_SELECTS && ctrl_r[VRC_BIT_SEC_SEL]) |-> o_analog.sec_src == VRC_SEC_SUPPLY)
        else $error("secondary select wrong");
    chk_zero_select: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_SHARED_PIN && !ctrl_r[VRC_BIT_PRI_SEL]) |-> o_analog.pri_src == VRC_PRI_SHARED_PIN)
        else $error("shared pin not chosen");

    chk_shared_sec_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_SHARED_PIN && !ctrl_r[VRC_BIT_SEC_SEL])
        |-> o_analog.sec_src == VRC_SEC_SHARED_PIN)
        else $error("shared pin not chosen for secondary");

    // With separate pins, a clear select picks each converter's own pin.
    chk_sep_pri_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_SEPARATE_PINS && !ctrl_r[VRC_BIT_PRI_SEL])
        |-> o_analog.pri_src == VRC_PRI_SEP_PIN)
        else $error("primary pin not chosen");

    chk_sep_sec_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_SEPARATE_PINS && !ctrl_r[VRC_BIT_SEC_SEL])
        |-> o_analog.sec_src == VRC_SEC_SEP_PIN)
        else $error("secondary pin not chosen");

    // Without a mux the select bits are neither stored nor decoded.
    chk_nosel_none: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_NO_SELECTS)
        |-> o_analog.pri_src == VRC_PRI_NONE && o_analog.sec_src == VRC_SEC_NONE)
        else $error("select driven in no-select build");

    chk_nosel_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (VARIANT == VRC_NO_SELECTS)
        |-> !ctrl_r[VRC_BIT_PRI_SEL] && !ctrl_r[VRC_BIT_SEC_SEL])
        else $error("reserved select bits stored");

    // Main scenarios that the checks above should see at least once.
    cov_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_req.wr && sel);
    cov_read: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_req.rd && sel);
    cov_all_on: cover property (@(posedge i_mclk) disable iff (!i_rst_n) ctrl_r[2:0] == 3'b111);
    cov_wr_rd_same: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_req.wr && i_req.rd && sel);
    cov_both_sel: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
        ctrl_r[VRC_BIT_PRI_SEL] && ctrl_r[VRC_BIT_SEC_SEL]);
endmodule
`default_nettype wire

/* File: verif/vrc_reference_control_test.sv */
// Testbench for the reference control register in all three build variants.
`timescale 1ns/1ps
`default_nettype none
module vrc_reference_control_test;
    import vrc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    vrc_sfr_req_t req = '0;
    logic [7:0] rd_a, rd_b, rd_c;
    logic hit_a, hit_b, hit_c, mux_a, oe_a;
    vrc_analog_t an_a, an_b, an_c;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    // All variants share one request so that each write is judged three ways at once.
    vrc_reference_control #(.VARIANT(VRC_SEPARATE_PINS)) uut (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rd_a), .o_hit(hit_a),
        .o_analog(an_a), .o_sensor_mux_en(mux_a), .o_ref_buf_oe(oe_a));
    vrc_reference_control #(.VARIANT(VRC_SHARED_PIN)) uut_sh (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rd_b), .o_hit(hit_b),
        .o_analog(an_b), .o_sensor_mux_en(), .o_ref_buf_oe());
    vrc_reference_control #(.VARIANT(VRC_NO_SELECTS)) uut_ns (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rd_c), .o_hit(hit_c),
        .o_analog(an_c), .o_sensor_mux_en(), .o_ref_buf_oe());
    // Free-running system clock.
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    // A hang is cut short well past the forty or so cycles the run needs.
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_count = err_count + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus cycle; the request stands a single cycle, outputs are settled on return.
    task automatic xfer(input logic w, input logic r, input logic [3:0] pg,
                        input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_mclk);
        req <= {w, r, pg, ad, d};
        @(posedge i_mclk);
        req <= '0;
        #1;
    endtask
    // Read data stands exactly one cycle and then falls back to zero.
    task automatic read_exp(input logic [7:0] ea, input logic [7:0] ec);
        xfer(1'b0, 1'b1, 4'h0, VRC_REF_CTRL_ADDR, 8'h00_00);
        chk({7'h0, hit_a & hit_b & hit_c}, 8'h00_01);
        chk(rd_a, ea);
        chk(rd_b, ea);
        chk(rd_c, ec);
        @(posedge i_mclk);
        #1;
        chk({hit_a, rd_a[6:0]}, 8'h00_00);
    endtask
    // Expected analog fields per variant: pri, sec, temp, bias, buf.
    task automatic an_exp(input logic [6:0] ea, input logic [6:0] eb, input logic [6:0] ec);
        chk({1'b0, an_a}, {1'b0, ea});
        chk({1'b0, an_b}, {1'b0, eb});
        chk({1'b0, an_c}, {1'b0, ec});
        chk({6'h0, mux_a, oe_a}, {6'h0, ea[2], ea[0]});
    endtask
    task automatic t_reset();
        an_exp({VRC_PRI_SEP_PIN, VRC_SEC_SEP_PIN, 3'b000}, {VRC_PRI_SHARED_PIN,
            VRC_SEC_SHARED_PIN, 3'b000}, {VRC_PRI_NONE, VRC_SEC_NONE, 3'b000});
        read_exp(8'h00_00, 8'h00_00);
    endtask
    task automatic t_all_ones();
        xfer(1'b1, 1'b0, 4'h0, VRC_REF_CTRL_ADDR, 8'h00_FF);
        an_exp({VRC_PRI_CONV_OUT, VRC_SEC_SUPPLY, 3'b111}, {VRC_PRI_CONV_OUT,
            VRC_SEC_SUPPLY, 3'b111}, {VRC_PRI_NONE, VRC_SEC_NONE, 3'b111});
        read_exp(8'h00_1F, 8'h00_07);
    endtask
    // Writes and reads off the register's page or address must change nothing.
    task automatic t_miss();
        xfer(1'b1, 1'b0, 4'h1, VRC_REF_CTRL_ADDR, 8'h00_00);
        xfer(1'b1, 1'b0, 4'h0, 8'h00_D2, 8'h00_00);
        xfer(1'b0, 1'b1, 4'h0, 8'h00_D0, 8'h00_00);
        chk({hit_a, rd_a[6:0]}, 8'h00_00);
        read_exp(8'h00_1F, 8'h00_07);
    endtask
    // Each select alone, with a write and read together returning the old value.
    task automatic t_selects();
        xfer(1'b1, 1'b0, 4'h0, VRC_REF_CTRL_ADDR, 8'h00_15);
        an_exp({VRC_PRI_CONV_OUT, VRC_SEC_SEP_PIN, 3'b101}, {VRC_PRI_CONV_OUT,
            VRC_SEC_SHARED_PIN, 3'b101}, {VRC_PRI_NONE, VRC_SEC_NONE, 3'b101});
        xfer(1'b1, 1'b1, 4'h0, VRC_REF_CTRL_ADDR, 8'h00_0A);
        chk(rd_a, 8'h00_15);
        chk(rd_c, 8'h00_05);
        an_exp({VRC_PRI_SEP_PIN, VRC_SEC_SUPPLY, 3'b010}, {VRC_PRI_SHARED_PIN,
            VRC_SEC_SUPPLY, 3'b010}, {VRC_PRI_NONE, VRC_SEC_NONE, 3'b010});
        read_exp(8'h00_0A, 8'h00_02);
    endtask
    // A reset in mid-run clears everything at once, without waiting for a clock edge.
    task automatic t_mid_reset();
        xfer(1'b1, 1'b0, 4'h0, VRC_REF_CTRL_ADDR, 8'h00_17);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        #1;
        an_exp({VRC_PRI_SEP_PIN, VRC_SEC_SEP_PIN, 3'b000}, {VRC_PRI_SHARED_PIN,
            VRC_SEC_SHARED_PIN, 3'b000}, {VRC_PRI_NONE, VRC_SEC_NONE, 3'b000});
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        #1;
        read_exp(8'h00_00, 8'h00_00);
    endtask
    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        #1;
        t_reset();
        t_all_ones();
        t_miss();
        t_selects();
        t_mid_reset();
        summarize();
    end
endmodule
`default_nettype wire
